// [sim/fwsp_host_model.sv]
// host serial controller model driving select, clock and serial in
`timescale 1ns/1ps
module fwsp_host_model (
  // clock
  input  wire logic core_clk_i,
  // serial pins
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end
  // ----------------------------------------
  // one framed command, mode 0, msb first
  // ----------------------------------------
  task automatic xfer(input logic [7:0] op, input logic [31:0] d, input int n, output logic [7:0] rd);
    logic [39:0] sh;
    int          i;
    sh = {op, d};
    rd = 8'h00;
    @(posedge core_clk_i);
    #1 cs_n_o = 1'b0;
    for (i = 0; i < 8 + n; i++) begin
      si_o = sh[39];
      sh   = sh << 1;
      repeat (4) @(posedge core_clk_i);
      #1 sclk_o = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1 rd = {rd[6:0], so_i};
      sclk_o = 1'b0;
    end
    repeat (4) @(posedge core_clk_i);
    #1 cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
endmodule // fwsp_host_model

// [sim/fwsp_status_protect_bench.sv]
// self-checking bench for the status and protection block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, a); end end
module fwsp_status_protect_bench;
  logic        core_clk_i;
  logic        nrst_i;
  logic        wp_n;
  logic        cs_n;
  logic        sclk;
  logic        si;
  wire  [3:0]  io_o;
  wire  [3:0]  io_oe_o;
  wire  [15:0] status_o;
  wire         wp_n_o;
  wire         pause_n_o;
  wire         so;
  logic [7:0]  rd;
  int          err_total;
  int          cmp_count;
  assign so = io_oe_o[1] ? io_o[1] : 1'b1;
  fwsp_status_protect #(.T_STAT_WR(16'h00c8), .T_PROG(16'h0096), .T_ERASE(16'h00c8)) i_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i({1'b1, wp_n, so, si}),
    .io_o(io_o), .io_oe_o(io_oe_o), .status_o(status_o), .wp_n_o(wp_n_o), .pause_n_o(pause_n_o));
  fwsp_host_model i_host (.core_clk_i(core_clk_i), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmd(input logic [7:0] op);
    i_host.xfer(op, 32'h0, 0, rd);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && status_o[0] !== 1'b0; k++) begin
      @(posedge core_clk_i);
      #1;
    end
    `CHK("idle", 1'b0, status_o[0])
    #1;
  endtask
  task automatic status_write_cmd(input logic [15:0] v, input int n);
    cmd(8'h06);
    i_host.xfer(8'h01, {v[7:0], v[15:8], 16'h0}, n, rd);
    wait_idle();
  endtask
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_latch();
    `CHK("rst", 16'h0000, status_o)
    cmd(8'h06);
    `CHK("wel set", 1'b1, status_o[1])
    i_host.xfer(8'h05, 32'h0, 8, rd);
    `CHK("rd lo", 8'h02, rd)
    `CHK("wel kept", 1'b1, status_o[1])
    cmd(8'h04);
    `CHK("wel clr", 1'b0, status_o[1])
  endtask
  task automatic t_status_write_cmd();
    wp_n = 1'b0;
    i_host.xfer(8'h01, 32'h7c000000, 8, rd);
    `CHK("no wel", 16'h0000, status_o)
    cmd(8'h06);
    i_host.xfer(8'h01, 32'h7fc60000, 16, rd);
    i_host.xfer(8'h05, 32'h0, 8, rd);
    `CHK("busy rd", 1'b1, rd[0])
    wait_idle();
    `CHK("sr16", 16'h427c, status_o)
    `CHK("quad pins", 2'b11, {wp_n_o, pause_n_o})
    i_host.xfer(8'h35, 32'h0, 8, rd);
    `CHK("rd hi", 8'h42, rd)
    status_write_cmd(16'h00ff, 8);
    `CHK("sr8", 16'h00fc, status_o)
    `CHK("wp pin", 1'b0, wp_n_o)
  endtask
  task automatic t_lock();
    status_write_cmd(16'h0000, 8);
    `CHK("hw lock", 14'h003f, status_o[15:2])
    wp_n = 1'b1;
    status_write_cmd(16'h0100, 16);
    `CHK("hw open", 16'h0100, status_o)
    status_write_cmd(16'h0000, 16);
    `CHK("pwr lock", 14'h0040, status_o[15:2])
    nrst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK("pwr cyc", 16'h0000, status_o)
    wp_n = 1'b0;
    cmd(8'h50);
    i_host.xfer(8'h01, 32'h04000000, 8, rd);
    wait_idle();
    `CHK("vol wr", 16'h0004, status_o)
    status_write_cmd(16'h0804, 16);
    `CHK("sw mode", 16'h0804, status_o)
    status_write_cmd(16'h0010, 12);
    `CHK("bad len", 14'h0201, status_o[15:2])
  endtask
  task automatic t_erase();
    cmd(8'h06);
    cmd(8'h60);
    `CHK("ce prot", 16'h0804, status_o)
    status_write_cmd(16'h0000, 16);
    `CHK("lock kept", 16'h0800, status_o)
    cmd(8'h06);
    i_host.xfer(8'h44, 32'h00100000, 24, rd);
    `CHK("sec lock", 2'b10, status_o[1:0])
    i_host.xfer(8'h44, 32'h00200000, 24, rd);
    `CHK("sec open", 1'b1, status_o[0])
    wait_idle();
    cmd(8'h06);
    cmd(8'hc7);
    `CHK("ce busy", 1'b1, status_o[0])
    cmd(8'h75);
    `CHK("era sus", 1'b1, status_o[15])
    cmd(8'h7a);
    `CHK("resume a", 1'b0, status_o[15])
    wait_idle();
    `CHK("ce wel", 1'b0, status_o[1])
    cmd(8'h06);
    i_host.xfer(8'h02, 32'h00000055, 32, rd);
    cmd(8'hb0);
    `CHK("prg sus", 1'b1, status_o[10])
    cmd(8'h30);
    `CHK("resume b", 1'b0, status_o[10])
    wait_idle();
    `CHK("pp wel", 1'b0, status_o[1])
  endtask
  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    nrst_i = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    t_latch();
    t_status_write_cmd();
    t_lock();
    t_erase();
    finish_test();
  end
  initial begin
    #600000;
    err_total++;
    finish_test();
  end
endmodule // fwsp_status_protect_bench

// [sim/fwsp_status_protect_properties.sv]
// port assertions for the status and protection block
`timescale 1ns/1ps
module fwsp_status_protect_chk (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  // pins and status
  input wire logic        cs_n_i,
  input wire logic [3:0]  io_i,
  input wire logic [3:0]  io_oe_o,
  input wire logic [15:0] status_o,
  input wire logic        wp_n_o,
  input wire logic        pause_n_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_OE_LINE1: assert property (io_oe_o[3:2] == 2'b00 && !io_oe_o[0])
    else $error("enable on unused line");
  AST_OE_IDLE: assert property (cs_n_i [*8] |-> !io_oe_o[1])
    else $error("output driven outside frame");
  AST_OE_NEEDS_CS: assert property ($rose(io_oe_o[1]) |-> !cs_n_i)
    else $error("output enabled without select");
  AST_WEL_ONLY_FRAME: assert property (cs_n_i [*8] |-> !$rose(status_o[1]))
    else $error("latch set without frame");
  AST_WEL_CLR_DONE: assert property ($fell(status_o[0]) |-> ##[0:4] !status_o[1])
    else $error("latch kept after completion");
  AST_BUSY_MIN: assert property ($rose(status_o[0]) |-> status_o[0] [*4])
    else $error("busy too short");
  AST_BUSY_END: assert property ($rose(status_o[0]) |-> ##[1:1000] !status_o[0])
    else $error("busy never ends");
  AST_LOCK_STICKY: assert property (!$fell(status_o[11]) && !$fell(status_o[12]) && !$fell(status_o[13]))
    else $error("page lock cleared");
  AST_QUAD_PINS: assert property (status_o[9] && $past(status_o[9]) |-> wp_n_o && pause_n_o)
    else $error("pin function with quad on");
  AST_WP_FOLLOW: assert property ((!status_o[9] && !io_i[2]) [*5] |-> !wp_n_o)
    else $error("protect pin not seen");
  AST_SUSP_IN_FRAME: assert property (!cs_n_i |-> !$rose(status_o[15]) && !$rose(status_o[10]))
    else $error("paused flag rose mid frame");
  C_WEL: cover property ($rose(status_o[1]));
  C_BUSY: cover property ($rose(status_o[0]));
  C_ERA_SUS: cover property ($rose(status_o[15]));
  C_PRG_SUS: cover property ($rose(status_o[10]));
endmodule // fwsp_status_protect_chk
bind fwsp_status_protect fwsp_status_protect_chk i_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .io_i(io_i), .io_oe_o(io_oe_o),
  .status_o(status_o), .wp_n_o(wp_n_o), .pause_n_o(pause_n_o));

// [verilog/fwsp_consts.vh]
// constants for the flash write-enable and status protection block
// Summary of operation
// - latch-set opcode framed by chip select sets the write latch flag
// - latch-clear opcode framed by chip select clears the write latch flag
// - latch flag clears at reset and on completion of every modifying command
// - volatile enable precedes status write, keeps latch, write updates the same status register
// - status reads are accepted at any time, even while busy
// - low read opcode shifts status_low_byte, high read opcode shifts status_high_byte on output
// - bit zero is busy, high while program, erase or status write runs
// - bit one mirrors latch; without it program, erase refused, status write needs volatile enable instead
// - bits six..two are protect range, writable only outside hardware protect
// - chip erase executes only when protect range selects nothing
// - lock mode 00 allows status write whenever latch set
// - lock mode 01 refuses status write while protect pin low and quad enable clear
// - lock mode 10 and 11 both refuse until power cycle
// - quad enable frees protect and pause pins, holding both pin outputs high
// - three page lock bits at 13..11 set by status write, cleared only by reset
// - complement bit fourteen joins protect range to pick protected area
// - suspend sets erase paused bit 15 or program paused bit 10
// - resume opcode or power cycle clears both paused flags
// - secure register address: 23..16 zero, 15..9 pick register, 8..0 byte
// - status write leaves bits 15, 10, 1 and 0 unchanged
`ifndef FWSP_CONSTS_VH
`define FWSP_CONSTS_VH
`define FWSP_OP_LATCH_SET   8'h06
`define FWSP_OP_LATCH_CLR   8'h04
`define FWSP_OP_VOL_EN      8'h50
`define FWSP_OP_STAT_LO     8'h05
`define FWSP_OP_STAT_HI     8'h35
`define FWSP_OP_STAT_WR     8'h01
`define FWSP_OP_PAGE_PROG   8'h02
`define FWSP_OP_DUAL_PROG   8'ha2
`define FWSP_OP_QUAD_PROG   8'h32
`define FWSP_OP_PAGE_ERASE  8'h81
`define FWSP_OP_SECT_ERASE  8'h20
`define FWSP_OP_HBLK_ERASE  8'h52
`define FWSP_OP_BLK_ERASE   8'hd8
`define FWSP_OP_CHIP_ERA_A  8'h60
`define FWSP_OP_CHIP_ERA_B  8'hc7
`define FWSP_OP_SEC_ERASE   8'h44
`define FWSP_OP_SEC_PROG    8'h42
`define FWSP_OP_SUSP_A      8'h75
`define FWSP_OP_SUSP_B      8'hb0
`define FWSP_OP_RESUME_A    8'h7a
`define FWSP_OP_RESUME_B    8'h30
`define FWSP_OP_RST_EN      8'h66
`define FWSP_OP_RST         8'h99
`define FWSP_BIT_BUSY       0
`define FWSP_BIT_LATCH      1
`define FWSP_BIT_PROG_SUS   10
`define FWSP_BIT_ERASE_SUS  15
`define FWSP_BIT_LOCK_LO    7
`define FWSP_BIT_LOCK_HI    8
`define FWSP_BIT_QUAD       9
`define FWSP_BIT_INVERT     14
`define FWSP_STAT_RESET     16'h0000
`define FWSP_WRITABLE_MASK  16'h7bfc
`define FWSP_PROT_MASK      16'h007c
`define FWSP_LOCKS_MASK     16'h3800
`define FWSP_SEC_SEL_1      7'h08
`define FWSP_SEC_SEL_2      7'h10
`define FWSP_SEC_SEL_3      7'h18
`define FWSP_T_STAT_WR_NS   1000
`define FWSP_T_PROG_NS      2000
`define FWSP_T_ERASE_NS     4000
`define FWSP_CLK_NS         20
`define FWSP_CYC_STAT_WR    ((`FWSP_T_STAT_WR_NS + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)
`define FWSP_CYC_PROG       ((`FWSP_T_PROG_NS + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)
`define FWSP_CYC_ERASE      ((`FWSP_T_ERASE_NS + `FWSP_CLK_NS - 1) / `FWSP_CLK_NS)
`endif

// [verilog/fwsp_status_protect.v]
// serial flash write-enable latch and status register protection logic
`timescale 1ns/1ps
`include "fwsp_consts.vh"
module fwsp_status_protect #(
  parameter [15:0] T_STAT_WR = `FWSP_CYC_STAT_WR,
  parameter [15:0] T_PROG    = `FWSP_CYC_PROG,
  parameter [15:0] T_ERASE   = `FWSP_CYC_ERASE
) (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        nrst_i,
  // serial pins
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire [3:0]  io_i,
  output wire [3:0]  io_o,
  output wire [3:0]  io_oe_o,
  // status view
  output wire [15:0] status_o,
  output wire        wp_n_o,
  output wire        pause_n_o
);
  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [6:0] pin_s;
  fwsp_sync #(.W(7)) u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    ({io_i, sclk_i, ~cs_n_i, 1'b0}),
    .sync_o     (pin_s)
  );
  // select travels inverted so that a freshly reset sync bank reads as deselected
  wire       cs_n_s = ~pin_s[1];
  wire       sclk_s = pin_s[2];
  wire [3:0] io_s   = pin_s[6:3];

  reg        sclk_d_ff;
  reg        cs_n_d_ff;
  wire       sclk_rise = sclk_s & ~sclk_d_ff;
  wire       sclk_fall = ~sclk_s & sclk_d_ff;
  wire       cs_rise   = cs_n_s & ~cs_n_d_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function is_prog_op;
    input [7:0] op;
    begin
      is_prog_op = (op == `FWSP_OP_PAGE_PROG) || (op == `FWSP_OP_DUAL_PROG) ||
                   (op == `FWSP_OP_QUAD_PROG) || (op == `FWSP_OP_SEC_PROG);
    end
  endfunction

  function is_erase_op;
    input [7:0] op;
    begin
      is_erase_op = (op == `FWSP_OP_PAGE_ERASE) || (op == `FWSP_OP_SECT_ERASE) ||
                    (op == `FWSP_OP_HBLK_ERASE) || (op == `FWSP_OP_BLK_ERASE) ||
                    (op == `FWSP_OP_CHIP_ERA_A) || (op == `FWSP_OP_CHIP_ERA_B) ||
                    (op == `FWSP_OP_SEC_ERASE);
    end
  endfunction

  function is_chip_erase;
    input [7:0] op;
    begin
      is_chip_erase = (op == `FWSP_OP_CHIP_ERA_A) || (op == `FWSP_OP_CHIP_ERA_B);
    end
  endfunction

  // secure page address selects an unlocked page
  function sec_open;
    input [23:0] addr;
    input [2:0]  locks;
    begin
      sec_open = (addr[23:16] == 8'h00) &&
                 (((addr[15:9] == `FWSP_SEC_SEL_1) && !locks[0]) ||
                  ((addr[15:9] == `FWSP_SEC_SEL_2) && !locks[1]) ||
                  ((addr[15:9] == `FWSP_SEC_SEL_3) && !locks[2]));
    end
  endfunction

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_OPC  = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  localparam [1:0] ST_OUT  = 2'b11;

  reg [1:0]  state_ff;
  reg [5:0]  bit_cnt_ff;
  reg [7:0]  opcode_ff;
  reg [15:0] shift_ff;
  reg [7:0]  out_byte_ff;
  reg        so_ff;
  reg        so_oe_ff;
  reg        wait_rst_ff;
  reg [23:0] addr_ff;

  // status bits
  reg        write_latch_flag_ff;
  reg        vol_en_ff;
  reg        busy_flag_ff;
  reg [15:0] nv_stat_ff;
  reg        erase_paused_flag_ff;
  reg        program_paused_flag_ff;
  reg [15:0] op_cnt_ff;
  reg        op_is_sw_ff;
  reg        op_is_erase_ff;

  wire lock_mode_low  = nv_stat_ff[`FWSP_BIT_LOCK_LO];
  wire lock_mode_high = nv_stat_ff[`FWSP_BIT_LOCK_HI];
  wire quad_io_enable = nv_stat_ff[`FWSP_BIT_QUAD];
  wire wp_n_pin       = io_s[2];

  // status write allowed under the lock mode
  wire stat_unlocked = (~lock_mode_high & ~lock_mode_low) |
                       (~lock_mode_high & lock_mode_low & (quad_io_enable | wp_n_pin));

  wire [15:0] status_word;
  assign status_word = {erase_paused_flag_ff, nv_stat_ff[14:11], program_paused_flag_ff,
                        nv_stat_ff[9:2], write_latch_flag_ff, busy_flag_ff};

  wire no_protect = ((nv_stat_ff & `FWSP_PROT_MASK) == 16'h0000) & ~nv_stat_ff[`FWSP_BIT_INVERT];

  // frame-end decisions
  wire frame_end   = cs_rise & (state_ff != ST_IDLE);
  wire op_done     = (bit_cnt_ff == 6'd8);
  wire end_set     = frame_end & op_done & (opcode_ff == `FWSP_OP_LATCH_SET) & ~busy_flag_ff;
  wire end_clr     = frame_end & op_done & (opcode_ff == `FWSP_OP_LATCH_CLR) & ~busy_flag_ff;
  wire end_vol     = frame_end & op_done & (opcode_ff == `FWSP_OP_VOL_EN) & ~busy_flag_ff;
  wire stat_len_ok = (bit_cnt_ff == 6'd16) | (bit_cnt_ff == 6'd24);
  wire end_wr      = frame_end & (opcode_ff == `FWSP_OP_STAT_WR) & stat_len_ok & ~busy_flag_ff &
                     (write_latch_flag_ff | vol_en_ff) & stat_unlocked;
  wire sec_op      = (opcode_ff == `FWSP_OP_SEC_PROG) | (opcode_ff == `FWSP_OP_SEC_ERASE);
  wire sec_ok      = ~sec_op | ((bit_cnt_ff >= 6'd32) & sec_open(addr_ff, nv_stat_ff[13:11]));
  wire end_prog    = frame_end & (bit_cnt_ff > 6'd8) & is_prog_op(opcode_ff) & ~busy_flag_ff &
                     write_latch_flag_ff & sec_ok;
  wire end_erase   = frame_end & (bit_cnt_ff > 6'd8) & is_erase_op(opcode_ff) & ~busy_flag_ff &
                     write_latch_flag_ff & sec_ok &
                     (~is_chip_erase(opcode_ff) | no_protect);
  wire chip_refuse = frame_end & op_done & is_chip_erase(opcode_ff) & ~busy_flag_ff &
                     write_latch_flag_ff & ~no_protect;
  wire end_chip    = frame_end & op_done & is_chip_erase(opcode_ff) & ~busy_flag_ff &
                     write_latch_flag_ff & no_protect;
  wire end_susp    = frame_end & op_done & busy_flag_ff & ~op_is_sw_ff &
                     ((opcode_ff == `FWSP_OP_SUSP_A) | (opcode_ff == `FWSP_OP_SUSP_B));
  wire end_resume  = frame_end & op_done &
                     ((opcode_ff == `FWSP_OP_RESUME_A) | (opcode_ff == `FWSP_OP_RESUME_B));
  wire end_reset   = frame_end & op_done & wait_rst_ff & (opcode_ff == `FWSP_OP_RST);
  wire op_finish   = busy_flag_ff & (op_cnt_ff == 16'h0001) &
                     ~erase_paused_flag_ff & ~program_paused_flag_ff;
  wire start_op    = end_wr | end_prog | end_erase | end_chip;

  // new status value keeps read-only bits and lock rules
  wire [15:0] wr_data  = (bit_cnt_ff == 6'd16) ? {8'h00, shift_ff[7:0]} :
                         {shift_ff[7:0], shift_ff[15:8]};
  wire [15:0] wr_mask  = `FWSP_WRITABLE_MASK;
  wire [15:0] nxt_stat = (nv_stat_ff & ~wr_mask) | (wr_data & wr_mask) |
                         (nv_stat_ff & `FWSP_LOCKS_MASK);

  // ----------------------------------------------------------------
  // serial frame decoder
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_d_ff   <= 1'b0;
      cs_n_d_ff   <= 1'b1;
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 6'd0;
      opcode_ff   <= 8'h00;
      shift_ff    <= 16'h0000;
      out_byte_ff <= 8'h00;
      addr_ff     <= 24'h000000;
      so_ff       <= 1'b0;
      so_oe_ff    <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
      if (cs_n_s) begin
        state_ff   <= ST_IDLE;
        bit_cnt_ff <= 6'd0;
        so_oe_ff   <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff   <= ST_OPC;
            bit_cnt_ff <= 6'd0;
          end
          ST_OPC: begin
            if (sclk_rise) begin
              opcode_ff  <= {opcode_ff[6:0], io_s[0]};
              bit_cnt_ff <= bit_cnt_ff + 6'd1;
              if (bit_cnt_ff == 6'd7) begin
                if ({opcode_ff[6:0], io_s[0]} == `FWSP_OP_STAT_LO) begin
                  state_ff    <= ST_OUT;
                  out_byte_ff <= status_word[7:0];
                end else if ({opcode_ff[6:0], io_s[0]} == `FWSP_OP_STAT_HI) begin
                  state_ff    <= ST_OUT;
                  out_byte_ff <= status_word[15:8];
                end else begin
                  state_ff <= ST_DATA;
                end
              end
            end
          end
          ST_DATA: begin
            if (sclk_rise && (bit_cnt_ff != 6'd63)) begin
              shift_ff   <= {shift_ff[14:0], io_s[0]};
              bit_cnt_ff <= bit_cnt_ff + 6'd1;
              if (bit_cnt_ff < 6'd32)
                addr_ff <= {addr_ff[22:0], io_s[0]};
            end
          end
          ST_OUT: begin
            if (sclk_fall) begin
              so_oe_ff    <= 1'b1;
              so_ff       <= out_byte_ff[7];
              out_byte_ff <= {out_byte_ff[6:0], out_byte_ff[7]};
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // status register and latch
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_latch_flag_ff    <= 1'b0;
      vol_en_ff              <= 1'b0;
      busy_flag_ff           <= 1'b0;
      nv_stat_ff             <= `FWSP_STAT_RESET;
      erase_paused_flag_ff   <= 1'b0;
      program_paused_flag_ff <= 1'b0;
      op_cnt_ff              <= 16'h0000;
      op_is_sw_ff            <= 1'b0;
      op_is_erase_ff         <= 1'b0;
      wait_rst_ff            <= 1'b0;
    end else begin
      if (frame_end)
        wait_rst_ff <= op_done & (opcode_ff == `FWSP_OP_RST_EN);
      if (end_set)
        write_latch_flag_ff <= 1'b1;
      else if (end_clr || chip_refuse || end_reset || op_finish)
        write_latch_flag_ff <= 1'b0;
      if (end_vol)
        vol_en_ff <= 1'b1;
      else if (end_wr || end_reset)
        vol_en_ff <= 1'b0;
      if (end_wr)
        nv_stat_ff <= nxt_stat;
      if (start_op) begin
        busy_flag_ff <= 1'b1;
        op_is_sw_ff  <= end_wr;
        op_is_erase_ff <= end_erase | end_chip;
        op_cnt_ff    <= end_wr ? T_STAT_WR : (end_prog ? T_PROG : T_ERASE);
      end else if (busy_flag_ff && !erase_paused_flag_ff && !program_paused_flag_ff) begin
        op_cnt_ff <= op_cnt_ff - 16'h0001;
        if (op_finish)
          busy_flag_ff <= 1'b0;
      end
      if (end_susp) begin
        if (op_is_erase_ff)
          erase_paused_flag_ff <= 1'b1;
        else
          program_paused_flag_ff <= 1'b1;
      end else if (end_resume || end_reset) begin
        erase_paused_flag_ff   <= 1'b0;
        program_paused_flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_o      = {2'b00, so_ff, 1'b0};
  assign io_oe_o   = {2'b00, so_oe_ff, 1'b0};
  assign status_o  = status_word;
  assign wp_n_o    = quad_io_enable ? 1'b1 : wp_n_pin;
  assign pause_n_o = quad_io_enable ? 1'b1 : io_s[3];
endmodule // fwsp_status_protect

// [verilog/fwsp_sync.v]
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module fwsp_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         core_clk_i,
  input  wire         nrst_i,
  // data
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule // fwsp_sync
